// *** hw/crt_defs.svh ***
// Purpose: offsets, reset values and timing counts of the cpu-bus responder
// Assumes: 250 MHz system clock, 32-bit Avalon-MM register port
// Notes: definitions only
`ifndef CRT_DEFS_SVH
`define CRT_DEFS_SVH

// ==========================================================
// register map (byte addresses)
`define CRT_OFS_CTRL 4'h0
`define CRT_OFS_MEMTOP 4'h4
`define CRT_OFS_STATUS 4'h8

// ==========================================================
// field positions and reset values
`define CRT_CTRL_DATA_RETRY_N_BIT 0
`define CRT_CTRL_RATIO_LSB 1
`define CRT_STAT_OWNER_BIT 0
`define CRT_STAT_BUSY_BIT 1
`define CRT_STAT_MEMSEL_BIT 5
`define CRT_CTRL_RST 32'h0000_0003
`define CRT_MEMTOP_RST 32'h0800_0000
`define CRT_RATIO_1TO1 2'h0
`define CRT_RATIO_2TO1 2'h1
`define CRT_RATIO_3TO1 2'h2

// ==========================================================
// clock limits and timing
`define CRT_CLK_MHZ 250
`define CRT_CPU_BUS_MAX_MHZ 66
`define CRT_PCI_BUS_MAX_MHZ 33
`define CRT_CLAIM_NS 8
`define CRT_CLAIM_CYC ((`CRT_CLAIM_NS * `CRT_CLK_MHZ + 999) / 1000)

// ==========================================================
// address decode boundaries
`define CRT_A_PCI_LO 32'h8000_0000
`define CRT_A_CFG0 32'h8080_0000
`define CRT_A_IO 32'h8100_0000
`define CRT_A_BCR 32'hbf80_0000
`define CRT_A_INTACK 32'hbfff_fff0
`define CRT_A_PMEM 32'hc000_0000
`define CRT_A_ROM 32'hffe0_0000
`define CRT_ALL_ONES 64'hffff_ffff_ffff_ffff

`endif

// *** hw/crt_pkg.sv ***
// Purpose: types shared by the cpu-bus responder and its bench
// Assumes: nothing
// Notes: constants live in crt_defs.svh
package crt_pkg;

    // ==========================================================
    // response class taken from the four transfer-kind bits
    typedef enum logic [2:0] {
        CLS_ADDR = 3'h0,
        CLS_WRITE = 3'h1,
        CLS_READ = 3'h2,
        CLS_KILL = 3'h3,
        CLS_ECO = 3'h4,
        CLS_ECI = 3'h5
    } crt_cls_type;

    // address-range target
    typedef enum logic [2:0] {
        TGT_MEM = 3'h0,
        TGT_PCI_IO = 3'h1,
        TGT_PCI_CFG = 3'h2,
        TGT_INTACK = 3'h3,
        TGT_PCI_MEM = 3'h4,
        TGT_ROM = 3'h5,
        TGT_BCR = 3'h6
    } crt_tgt_type;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_DECODE = 3'h1,
        S_WAIT = 3'h2,
        S_CHECK = 3'h3,
        S_CLAIM = 3'h4
    } crt_state_type;

    // one latched cpu-bus address tenure
    typedef struct packed {
        logic [3:0] code;
        logic extended_start_n;
        logic [31:0] addr;
    } crt_req_type;

    // operation handed to the memory or pci engine
    typedef struct packed {
        logic is_read;
        logic l2_inval;
        crt_tgt_type tgt;
        logic [31:0] addr;
    } crt_op_type;

endpackage

// *** hw/crt_responder.sv ***
// Purpose: cpu-bus slave, transfer-kind decode and response of the bridge
// Assumes: cpu bus runs synchronous to clk_sys_i; engines on same clock
// Notes: Avalon-MM slave holds mode, memory size and error status
//
// Behaviour
// - every cycle is classified as read, write or address-only response.
// - the fifth transfer-kind bit is ignored by classification.
// - class plus address range selects memory, pci, rom or register target.
// - address-only codes get address acknowledge only, nothing else.
// - codes 0001, 0011, 1001 are writes to memory or pci.
// - write-with-kill to memory also invalidates the level-two block.
// - read codes 0101, 0111, 1101, 1111 give identical reads.
// - external-control-out acked only when no other agent claims it.
// - external-control-in returns all ones when unclaimed, no pci.
// - bus ownership parks on the processor while idle.
// - only processor and snoop logic arbitrate for the bus.
// - one pipelined address held; memory writes are posted.
// - precise errors via error ack, imprecise via machine check.
// - extended-start transfers are refused as unsupported.
// - retry mode may present data that a later retry cancels.
// - no-retry mode acks read data only once it is final.
// - bus-to-pci ratio defaults 2:1, settable to 1:1 or 3:1.
// - cpu bus up to 66 MHz, pci up to 33 MHz.
// - unpopulated memory reads ones, drops writes, sets error bit 5.
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "crt_defs.svh"

module crt_responder
    import crt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ts_n_i,
    input wire logic extended_start_n_i,
    input wire logic [3:0] xfer_kind_code_i,
    input wire logic xfer_kind_extra_bit_i,
    input wire logic [31:0] addr_i,
    input wire logic claimed_n_i,
    input wire logic cpu_br_n_i,
    input wire logic snoop_req_i,
    input wire logic eng_done_i,
    input wire logic eng_err_i,
    input wire logic eng_cancel_i,
    input wire logic [63:0] eng_rdata_i,
    input wire logic async_err_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic addr_ack_n_o,
    output logic xfer_ack_n_o,
    output logic xfer_error_ack_n_o,
    output logic machine_check_n_o,
    output logic data_retry_n_o,
    output logic cpu_bg_n_o,
    output logic snoop_gnt_o,
    output logic [63:0] data_o,
    output logic data_oe_o,
    output logic op_start_o,
    output crt_op_type op_o,
    output logic [1:0] pci_ratio_o
);

    // ==========================================================
    // decode functions

    // only the four code bits enter; the extra bit never does
    function automatic crt_cls_type cls_f(input logic [3:0] c);
        unique case (c)
            4'h1, 4'h3, 4'h9: cls_f = CLS_WRITE;
            4'h5, 4'h7, 4'hd, 4'hf: cls_f = CLS_READ;
            4'h6: cls_f = CLS_KILL;
            4'ha: cls_f = CLS_ECO;
            4'he: cls_f = CLS_ECI;
            default: cls_f = CLS_ADDR;
        endcase
    endfunction

    // coarse range map; rom window shown as rom, remote rom not modelled
    function automatic crt_tgt_type tgt_f(input logic [31:0] a);
        if (a < `CRT_A_PCI_LO) begin
            tgt_f = TGT_MEM;
        end else if (a < `CRT_A_CFG0) begin
            tgt_f = TGT_PCI_IO;
        end else if (a < `CRT_A_IO) begin
            tgt_f = TGT_PCI_CFG;
        end else if (a < `CRT_A_BCR) begin
            tgt_f = TGT_PCI_IO;
        end else if (a == `CRT_A_INTACK) begin
            tgt_f = TGT_INTACK;
        end else if (a < `CRT_A_PMEM) begin
            tgt_f = TGT_BCR;
        end else if (a < `CRT_A_ROM) begin
            tgt_f = TGT_PCI_MEM;
        end else begin
            tgt_f = TGT_ROM;
        end
    endfunction

    function automatic logic [31:0] be_f(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        be_f = r;
    endfunction

    // ==========================================================
    // state and decode of the latched tenure
    crt_state_type state_r;
    crt_req_type cur_r;
    crt_req_type pend_r;
    logic pend_v_r;
    logic [31:0] ctrl_r;
    logic [31:0] memtop_r;
    logic memsel_err_r;
    logic memsel_set;
    logic [1:0] claim_cnt_r;
    logic snoop_own_r;
    crt_cls_type dec_cls;
    crt_tgt_type dec_tgt;
    logic dec_mem;
    logic dec_unpop;
    logic data_retry_n_mode;
    crt_req_type pin_req;

    assign pin_req = '{code: xfer_kind_code_i, extended_start_n: ~extended_start_n_i,
                       addr: addr_i};
    assign dec_cls = cls_f(cur_r.code);
    assign dec_tgt = tgt_f(cur_r.addr);
    assign dec_mem = (dec_tgt == TGT_MEM);
    assign dec_unpop = dec_mem && (cur_r.addr >= memtop_r);
    assign data_retry_n_mode = ctrl_r[`CRT_CTRL_DATA_RETRY_N_BIT];
    assign memsel_set = (state_r == S_DECODE) && !cur_r.extended_start_n && dec_unpop
                        && (dec_cls == CLS_READ || dec_cls == CLS_WRITE);

    // ==========================================================
    // tenure capture: one tenure in flight plus one queued
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cur_r <= '0;
            pend_r <= '0;
            pend_v_r <= 1'b0;
        end else if (state_r == S_IDLE) begin
            if (pend_v_r) begin
                cur_r <= pend_r;
                pend_v_r <= 1'b0;
            end else if (!ts_n_i) begin
                cur_r <= pin_req;
            end
        end else if (!ts_n_i && !pend_v_r) begin
            pend_r <= pin_req;
            pend_v_r <= 1'b1;
        end
    end

    // ==========================================================
    // response sequencer; acks are one-cycle active-low pulses
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            addr_ack_n_o <= 1'b1;
            xfer_ack_n_o <= 1'b1;
            xfer_error_ack_n_o <= 1'b1;
            data_retry_n_o <= 1'b1;
            data_o <= '0;
            data_oe_o <= 1'b0;
            op_start_o <= 1'b0;
            op_o <= '0;
            claim_cnt_r <= '0;
        end else begin
            addr_ack_n_o <= 1'b1;
            xfer_ack_n_o <= 1'b1;
            xfer_error_ack_n_o <= 1'b1;
            data_retry_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            op_start_o <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    if (pend_v_r || !ts_n_i) begin
                        state_r <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    addr_ack_n_o <= 1'b0;
                    op_o <= '{is_read: dec_cls == CLS_READ,
                              l2_inval: dec_mem
                                  && (cur_r.code == 4'h3
                                      || dec_cls == CLS_KILL),
                              tgt: dec_tgt, addr: cur_r.addr};
                    state_r <= S_IDLE;
                    if (cur_r.extended_start_n) begin
                        xfer_error_ack_n_o <= 1'b0;
                    end else begin
                        unique case (dec_cls)
                            CLS_ADDR: begin
                            end
                            CLS_KILL: begin
                                op_start_o <= dec_mem;
                            end
                            CLS_ECO, CLS_ECI: begin
                                addr_ack_n_o <= 1'b1;
                                claim_cnt_r <= 2'(`CRT_CLAIM_CYC);
                                state_r <= S_CLAIM;
                            end
                            CLS_WRITE: begin
                                if (dec_unpop) begin
                                    xfer_ack_n_o <= 1'b0;
                                end else if (dec_mem) begin
                                    op_start_o <= 1'b1;
                                    xfer_ack_n_o <= 1'b0;
                                end else begin
                                    op_start_o <= 1'b1;
                                    state_r <= S_WAIT;
                                end
                            end
                            CLS_READ: begin
                                if (dec_unpop) begin
                                    data_o <= `CRT_ALL_ONES;
                                    data_oe_o <= 1'b1;
                                    xfer_ack_n_o <= 1'b0;
                                end else begin
                                    op_start_o <= 1'b1;
                                    state_r <= S_WAIT;
                                end
                            end
                        endcase
                    end
                end
                S_CLAIM: begin
                    // another agent owns the cycle; stay silent
                    if (!claimed_n_i) begin
                        state_r <= S_IDLE;
                    end else if (claim_cnt_r <= 2'h1) begin
                        addr_ack_n_o <= 1'b0;
                        xfer_ack_n_o <= 1'b0;
                        if (cur_r.code == 4'he) begin
                            data_o <= `CRT_ALL_ONES;
                            data_oe_o <= 1'b1;
                        end
                        state_r <= S_IDLE;
                    end else begin
                        claim_cnt_r <= claim_cnt_r - 2'h1;
                    end
                end
                S_WAIT: begin
                    if (eng_done_i) begin
                        if (eng_err_i) begin
                            xfer_error_ack_n_o <= 1'b0;
                            state_r <= S_IDLE;
                        end else if (!op_o.is_read) begin
                            xfer_ack_n_o <= 1'b0;
                            state_r <= S_IDLE;
                        end else begin
                            data_o <= eng_rdata_i;
                            data_oe_o <= data_retry_n_mode;
                            xfer_ack_n_o <= !data_retry_n_mode;
                            state_r <= S_CHECK;
                        end
                    end
                end
                S_CHECK: begin
                    // cancel window: one cycle after the engine's data
                    if (eng_cancel_i) begin
                        data_retry_n_o <= !data_retry_n_mode;
                        state_r <= S_WAIT;
                    end else begin
                        if (!data_retry_n_mode) begin
                            data_oe_o <= 1'b1;
                            xfer_ack_n_o <= 1'b0;
                        end
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // bus parking: snoop logic only takes an idle bus
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            snoop_own_r <= 1'b0;
            cpu_bg_n_o <= 1'b0;
            snoop_gnt_o <= 1'b0;
        end else begin
            if (!snoop_req_i) begin
                snoop_own_r <= 1'b0;
                cpu_bg_n_o <= 1'b0;
                snoop_gnt_o <= 1'b0;
            end else if (state_r == S_IDLE && ts_n_i && !pend_v_r
                         && cpu_br_n_i) begin
                snoop_own_r <= 1'b1;
                cpu_bg_n_o <= 1'b1;
                snoop_gnt_o <= 1'b1;
            end
        end
    end

    // ==========================================================
    // imprecise errors from posted work
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            machine_check_n_o <= 1'b1;
        end else begin
            machine_check_n_o <= !async_err_i;
        end
    end

    // ==========================================================
    // Avalon slave: answer one cycle after the request is seen
    logic wr_now;
    assign wr_now = avs_write_i && !avs_waitrequest_o;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= '0;
            ctrl_r <= `CRT_CTRL_RST;
            memtop_r <= `CRT_MEMTOP_RST;
            pci_ratio_o <= `CRT_RATIO_2TO1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i)
                                   && avs_waitrequest_o);
            avs_readdata_o <= '0;
            if (avs_read_i && avs_waitrequest_o) begin
                unique case (avs_address_i)
                    `CRT_OFS_CTRL: avs_readdata_o <= ctrl_r;
                    `CRT_OFS_MEMTOP: avs_readdata_o <= memtop_r;
                    `CRT_OFS_STATUS: begin
                        avs_readdata_o[`CRT_STAT_OWNER_BIT] <= snoop_own_r;
                        avs_readdata_o[`CRT_STAT_BUSY_BIT] <=
                            (state_r != S_IDLE);
                        avs_readdata_o[`CRT_STAT_MEMSEL_BIT] <= memsel_err_r;
                    end
                    default: avs_readdata_o <= '0;
                endcase
            end
            if (wr_now && avs_address_i == `CRT_OFS_CTRL) begin
                ctrl_r <= be_f(ctrl_r, avs_writedata_i, avs_byteenable_i);
            end
            if (wr_now && avs_address_i == `CRT_OFS_MEMTOP) begin
                memtop_r <= be_f(memtop_r, avs_writedata_i,
                                 avs_byteenable_i);
            end
            // ratio beyond 3:1 is not a legal setting; keep the old one
            if (ctrl_r[`CRT_CTRL_RATIO_LSB +: 2] != 2'h3) begin
                pci_ratio_o <= ctrl_r[`CRT_CTRL_RATIO_LSB +: 2];
            end
        end
    end

    // sticky memory-select error; a new event beats the clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            memsel_err_r <= 1'b0;
        end else if (memsel_set) begin
            memsel_err_r <= 1'b1;
        end else if (wr_now && avs_address_i == `CRT_OFS_STATUS
                     && avs_byteenable_i[0]
                     && avs_writedata_i[`CRT_STAT_MEMSEL_BIT]) begin
            memsel_err_r <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence dec_s(crt_cls_type c);
        state_r == S_DECODE && !cur_r.extended_start_n && dec_cls == c;
    endsequence
    sequence ack_only_s;
        !addr_ack_n_o && xfer_ack_n_o && !op_start_o;
    endsequence

    addr_only_ack_a: assert property (
        dec_s(CLS_ADDR) |=> ack_only_s)
        else $error("address-only cycle did more than ack");
    posted_write_a: assert property (
        dec_s(CLS_WRITE) and dec_mem && !dec_unpop
        |=> op_start_o && !op_o.is_read && !xfer_ack_n_o)
        else $error("memory write not posted");
    kill_inval_a: assert property (
        state_r == S_DECODE && dec_mem && cur_r.code == 4'h3
        |=> op_o.l2_inval)
        else $error("write with kill missed invalidate");
    claim_quiet_a: assert property (
        state_r == S_CLAIM && !claimed_n_i |=> xfer_ack_n_o[*2])
        else $error("claimed cycle acked");
    eci_ones_a: assert property (
        state_r == S_CLAIM && cur_r.code == 4'he && claimed_n_i
        && claim_cnt_r <= 2'h1
        |=> !xfer_ack_n_o && data_oe_o && data_o == `CRT_ALL_ONES)
        else $error("control-in data not all ones");
    park_cpu_a: assert property (
        !snoop_req_i |=> !cpu_bg_n_o && !snoop_gnt_o)
        else $error("bus not parked on processor");
    precise_err_a: assert property (
        state_r == S_WAIT && eng_done_i && eng_err_i
        |=> !xfer_error_ack_n_o && xfer_ack_n_o)
        else $error("engine error not reported");
    extended_start_n_refuse_a: assert property (
        state_r == S_DECODE && cur_r.extended_start_n |=> !xfer_error_ack_n_o)
        else $error("extended start not refused");
    final_data_a: assert property (
        !data_retry_n_mode && state_r == S_CHECK && eng_cancel_i
        |=> xfer_ack_n_o && data_retry_n_o)
        else $error("cancelled data acked in no-retry mode");
    unpop_read_a: assert property (
        dec_s(CLS_READ) and dec_unpop
        |=> !xfer_ack_n_o && data_o == `CRT_ALL_ONES ##1 memsel_err_r)
        else $error("unpopulated read mishandled");

endmodule

`default_nettype wire

// *** tb/crt_cpu_model.sv ***
// Purpose: processor model driving address tenures on the cpu bus
// Assumes: single master; the bridge parks the bus on it
// Notes: tenures are started by the bench through start()
`timescale 1ns/1ps
`default_nettype none

module crt_cpu_model (
    input wire logic clk_i,
    output logic ts_n_o,
    output logic extended_start_n_n_o,
    output logic [3:0] code_o,
    output logic xbit_o,
    output logic [31:0] addr_o
);
    // straps the modelled processor is wired with; bus timing ignores them
    localparam logic [3:0] strap_small = 4'hc;
    localparam logic [3:0] strap_large = 4'h4;

    // ==========================================================
    // idle bus at time zero
    initial begin
        ts_n_o = 1'b1;
        extended_start_n_n_o = 1'b1;
        code_o = 4'h0;
        xbit_o = 1'b0;
        addr_o = 32'h0;
    end

    // one-cycle start strobe, then lines scrambled: nothing holds them
    task start(input logic [3:0] c, input logic [31:0] a, input logic x);
        ts_n_o <= 1'b0;
        extended_start_n_n_o <= x;
        code_o <= c;
        xbit_o <= 1'($urandom);
        addr_o <= a;
        @(posedge clk_i);
        ts_n_o <= 1'b1;
        extended_start_n_n_o <= 1'b1;
        code_o <= ~c;
        addr_o <= ~a;
    endtask
endmodule
`default_nettype wire

// *** tb/crt_responder_tb_top.sv ***
// Purpose: self-checking bench of the cpu-bus responder
// Assumes: engine answers after a random wait; 250 MHz clock
// Notes: each address ack is matched against the oldest note
`timescale 1ns/1ps
`default_nettype none
`include "crt_defs.svh"

module crt_responder_tb_top;
    import crt_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ts_n, extended_start_n_n, xbit, wreq, addr_ack_n_n, ta_n, tea_n, mcp_n, bg_n, oe, st;
    logic claimed_n = 1'b1;
    logic err = 1'b0;
    logic snp = 1'b0;
    logic gnt;
    logic done = 1'b0;
    logic async_err = 1'b0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [3:0] av_a = 4'h0;
    logic [3:0] code;
    logic [31:0] addr, av_q, op_a;
    logic [31:0] av_wd = 32'h0;
    logic [63:0] dout;
    logic [63:0] rdata = 64'h0;
    logic [1:0] ratio;
    crt_op_type op;
    logic [3:0] ao[6] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hb, 4'hc};
    logic [3:0] wc[3] = '{4'h1, 4'h3, 4'h9};
    logic [3:0] rc[4] = '{4'h5, 4'h7, 4'hd, 4'hf};
    logic [7:0] notes[$];
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int dly = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    crt_cpu_model u_crt_cpu_model (.clk_i(clk_sys_i), .ts_n_o(ts_n),
        .extended_start_n_n_o(extended_start_n_n), .code_o(code), .xbit_o(xbit), .addr_o(addr));

    // ==========================================================
    // design under test; processor never asserts its bus request
    crt_responder u_crt_responder (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .ts_n_i(ts_n), .extended_start_n_i(extended_start_n_n),
        .xfer_kind_code_i(code), .xfer_kind_extra_bit_i(xbit),
        .addr_i(addr), .claimed_n_i(claimed_n), .cpu_br_n_i(1'b1),
        .snoop_req_i(snp), .eng_done_i(done), .eng_err_i(err),
        .eng_cancel_i(1'b0), .eng_rdata_i(rdata), .async_err_i(async_err),
        .avs_address_i(av_a), .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(av_q), .avs_waitrequest_o(wreq),
        .addr_ack_n_o(addr_ack_n_n), .xfer_ack_n_o(ta_n),
        .xfer_error_ack_n_o(tea_n), .machine_check_n_o(mcp_n),
        .data_retry_n_o(), .cpu_bg_n_o(bg_n), .snoop_gnt_o(gnt),
        .data_o(dout), .data_oe_o(oe), .op_start_o(st), .op_o(op),
        .pci_ratio_o(ratio));

    // ==========================================================
    // engine: reads and pci ops finish after 1..4 cycles
    always @(posedge clk_sys_i) begin
        done <= (dly == 1);
        rdata <= (dly == 1) ? {2{op_a}} : ~rdata; // junk outside done
        dly <= (dly > 0) ? dly - 1 : 0;
        if (st === 1'b1 && (op.is_read || op.tgt != TGT_MEM)) begin
            dly <= 1 + $urandom % 4;
            op_a <= op.addr;
        end
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            close_out();
        end
    end

    // monitor: {err, oe, start, read, l2 inval, target} at address ack
    always @(posedge clk_sys_i) begin
        if (rst_i === 1'b0 && addr_ack_n_n === 1'b0)
            check("addr_ack_n", notes.size() ? notes.pop_front() : 8'h07,
                {~tea_n, oe, st, st ? {op.is_read, op.l2_inval, op.tgt} :
                5'h0});
    end

    task automatic check(input string w, input logic [63:0] e,
                         input logic [63:0] s);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask

    // one tenure; note 8'h07 means no acknowledge may come
    task automatic ten(input logic [3:0] c, input logic [31:0] a,
                       input logic x, input logic [7:0] n);
        int i;
        if (n != 8'h07)
            notes.push_back(n);
        u_crt_cpu_model.start(c, a, x);
        for (i = 0; i < 30 && addr_ack_n_n !== 1'b0; i++)
            @(posedge clk_sys_i);
        if (n[6])
            check("ones", `CRT_ALL_ONES, dout);
        for (i = 0; n[4] && i < 30 && ta_n !== 1'b0; i++)
            @(posedge clk_sys_i);
        if (n[4])
            check("rdata", {2{a}}, dout);
        repeat (2) @(posedge clk_sys_i);
    endtask

    // avalon access, held until waitrequest is sampled low
    task automatic av(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [31:0] e);
        av_a <= a;
        av_wr <= w;
        av_rd <= !w;
        av_wd <= d;
        @(posedge clk_sys_i);
        while (wreq !== 1'b0)
            @(posedge clk_sys_i);
        if (!w)
            check("avs", e, av_q);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        void'($urandom(75));
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        check("park", 1'b0, bg_n);
        av(1'b0, `CRT_OFS_CTRL, 32'h0, `CRT_CTRL_RST);
        av(1'b0, 4'hc, 32'h0, 32'h0);
        $display("test registers done");
        foreach (ao[k])
            ten(ao[k], $urandom, 1'b1, 8'h00);
        ten(4'h6, 32'hc000_0040, 1'b1, 8'h00);
        ten(4'h6, 32'h0000_0040, 1'b1, 8'h28);
        foreach (wc[k])
            ten(wc[k], 32'h100, 1'b1, {4'h2, wc[k] == 4'h3, 3'h0});
        ten(4'h1, 32'h8100_0000, 1'b1, 8'h21);
        foreach (rc[k]) begin
            ten(rc[k], 32'hc000_1000, 1'b1, 8'h34);
            ten(rc[k], 32'h0000_0200, 1'b1, 8'h30);
        end
        $display("test decode done");
        ten(4'he, 32'h300, 1'b1, 8'h40);
        ten(4'ha, 32'h300, 1'b1, 8'h00);
        claimed_n <= 1'b0;
        ten(4'ha, 32'h300, 1'b1, 8'h07);
        claimed_n <= 1'b1;
        ten(4'h5, 32'h100, 1'b0, 8'h80);
        ten(4'h5, 32'h1000_0000, 1'b1, 8'h40);
        av(1'b0, `CRT_OFS_STATUS, 32'h0, 32'h0000_0020);
        $display("test control done");
        av(1'b1, `CRT_OFS_CTRL, 32'h0000_0004, 32'h0);
        @(posedge clk_sys_i);
        check("ratio", 2'h2, ratio);
        err <= 1'b1;
        ten(4'h1, 32'h8100_0000, 1'b1, 8'h21);
        for (int i = 0; i < 30 && tea_n !== 1'b0; i++)
            @(posedge clk_sys_i);
        check("tea", 1'b0, tea_n);
        err <= 1'b0;
        ten(4'h5, 32'h0000_0200, 1'b1, 8'h30);
        async_err <= 1'b1;
        @(posedge clk_sys_i);
        async_err <= 1'b0;
        @(posedge clk_sys_i);
        check("mcheck", 1'b0, mcp_n);
        snp <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        check("grant", 2'h3, {bg_n, gnt});
        snp <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        check("parked", 2'h0, {bg_n, gnt});
        $display("test modes done");
        close_out();
    end
endmodule
`default_nettype wire
